/* File: core/tcou_timer_compare.sv */
// timer compare, overflow and group interrupt routing
// assumes register port and pins synchronous to mclk
`timescale 1ns/10ps
module tcou_timer_compare
    import tcou_pkg::*;
(
    // clock and resets
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkstop_rst,
    input wire logic ce_rst,
    // register port
    input wire tcou_req_t req,
    output logic [15:0] rdata,
    // timer controls
    input wire logic count_tick,
    input wire logic count_enable,
    input wire logic count_restart,
    input wire logic repeat_mode_flag,
    input wire logic overflow_clear,
    // interrupt control
    input wire logic timer_irq_permit_flag,
    input wire logic global_irq_enabled_state,
    input wire logic timer_irq_clear,
    input wire logic external_irq_pin,
    // status
    output logic timer_irq_pending_flag,
    output logic timer_irq_accept,
    output logic [11:0] timer_irq_vector,
    output logic count_overflow_flag,
    output logic shared_group_irq,
    output logic [11:0] count_value
);
    // decoded write strobes
    logic wr_cmp;
    logic wr_grp;

    // register state
    logic [11:0] compare_value_reg_r;
    logic [11:0] count_value_reg_r;
    logic [11:0] count_value_reg_nxt;
    logic [3:0] irq_group_select_reg_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // flags and event state
    logic pend_r;
    logic ovf_r;
    logic pin_r;
    logic group_r;
    logic accept_r;
    logic coincide_r;
    logic [11:0] vector_r;
    // combinational events
    logic group_source_select_bit;
    logic step_ok;
    logic coincide;
    logic cmp_hit;
    logic mod_return;
    logic wrap;
    logic ovf_evt;
    logic accept;
    logic pin_edge;
    logic group_evt;

    assign group_source_select_bit = irq_group_select_reg_r[TCOU_GRPSEL_BIT];
    assign step_ok = count_tick && count_enable && !ovf_r;
    assign coincide = count_value_reg_r == compare_value_reg_r;
    // one request per coincidence, even if the count holds between ticks
    assign cmp_hit = coincide && !coincide_r && count_enable;
    assign mod_return = step_ok && repeat_mode_flag && coincide;
    assign wrap = step_ok && count_value_reg_r == TCOU_CNT_MAX;
    // a modulo return at FFF is not an overflow
    assign ovf_evt = wrap && !mod_return;
    assign accept = pend_r && timer_irq_permit_flag &&
                    global_irq_enabled_state && !accept_r;
    assign pin_edge = external_irq_pin != pin_r;
    assign group_evt = group_source_select_bit ? ovf_evt : pin_edge;

    // write address decode
    always_comb begin
        wr_cmp = 1'b0;
        wr_grp = 1'b0;
        if (req.wr && req.addr == TCOU_ADDR_CMP) begin
            wr_cmp = 1'b1;
        end else if (req.wr && req.addr == TCOU_ADDR_GRPSEL) begin
            wr_grp = 1'b1;
        end
    end

    // compare register, low 12 bits only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            compare_value_reg_r <= TCOU_CMP_RST;
        end else if (wr_cmp) begin
            compare_value_reg_r <= req.wdata[11:0];
        end
    end

    // bits 3:1 are reserved and stay zero
    always_ff @(posedge mclk) begin
        if (!rstn || clkstop_rst || ce_rst) begin
            irq_group_select_reg_r <= TCOU_GRPSEL_RST;
        end else if (wr_grp) begin
            irq_group_select_reg_r <= {3'h0, req.wdata[TCOU_GRPSEL_BIT]};
        end
    end

    // free run parks at FFF; the overflow flag then stops it
    always_comb begin
        count_value_reg_nxt = count_value_reg_r;
        if (count_restart) begin
            count_value_reg_nxt = TCOU_CNT_ZERO;
        end else if (mod_return) begin
            count_value_reg_nxt = TCOU_CNT_ZERO;
        end else if (step_ok && count_value_reg_r != TCOU_CNT_MAX) begin
            count_value_reg_nxt = count_value_reg_r + 12'h001;
        end
    end

    // counter core
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            count_value_reg_r <= TCOU_CNT_ZERO;
        end else begin
            count_value_reg_r <= count_value_reg_nxt;
        end
    end

    // overflow flag, held across CE reset; set wins over clear
    always_ff @(posedge mclk) begin
        if (!rstn || clkstop_rst) begin
            ovf_r <= 1'b0;
        end else if (ovf_evt) begin
            ovf_r <= 1'b1;
        end else if (overflow_clear) begin
            ovf_r <= 1'b0;
        end
    end

    // delayed coincidence for the request edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            coincide_r <= 1'b0;
        end else begin
            coincide_r <= coincide;
        end
    end

    // pending flag: set wins over clear
    always_ff @(posedge mclk) begin
        if (!rstn || clkstop_rst || ce_rst) begin
            pend_r <= 1'b0;
        end else if (cmp_hit) begin
            pend_r <= 1'b1;
        end else if (accept || timer_irq_clear) begin
            pend_r <= 1'b0;
        end
    end

    // accept pulse; a second accept waits one cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            accept_r <= 1'b0;
        end else begin
            accept_r <= accept;
        end
    end

    // vector of the accepted timer request
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            vector_r <= TCOU_TIMER_VECTOR;
        end else begin
            vector_r <= TCOU_TIMER_VECTOR;
        end
    end

    // no reset: starts from the pin level, so no false edge after reset
    always_ff @(posedge mclk) begin
        pin_r <= external_irq_pin;
    end

    // shared group request, one-cycle pulse
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            group_r <= 1'b0;
        end else begin
            group_r <= group_evt;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (req.rd) begin
            if (req.addr == TCOU_ADDR_CMP) begin
                rdata_nxt = {4'h0, compare_value_reg_r};
            end else if (req.addr == TCOU_ADDR_COUNT) begin
                rdata_nxt = {4'h0, count_value_reg_r};
            end else if (req.addr == TCOU_ADDR_GRPSEL) begin
                rdata_nxt = {12'h000, irq_group_select_reg_r};
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
    assign timer_irq_pending_flag = pend_r;
    assign timer_irq_accept = accept_r;
    assign timer_irq_vector = vector_r;
    assign count_overflow_flag = ovf_r;
    assign shared_group_irq = group_r;
    assign count_value = count_value_reg_r;
endmodule // tcou_timer_compare

/* File: inc/tcou_pkg.sv */
// constants and carriers for the timer compare and overflow unit
// assumes a single mclk domain and synchronous active-low reset
// Summary of operation
// - modulo register holds the compare target for the timer interrupt.
// - detector compares count with modulo value, requests interrupt on equality.
// - each timer request sets the pending flag.
// - permit flag plus global enable accepts request, vector 0004H.
// - modulo mode clears the counter on coincidence.
// - only the low 12 bits of the written data are stored.
// - upper 4 bits ignore writes and read as zero.
// - counter overflow sets the overflow flag.
// - counter stops while the overflow flag is set.
// - group select 1 routes overflow to the shared group request.
// - group select 0 routes external pin edges to the shared request.
// - free-run mode counts to FFFH then stops at the next count clock.
// - modulo mode counts to the modulo value, returns to 000H, resumes.
package tcou_pkg;
    localparam logic [6:0] TCOU_ADDR_GRPSEL = 7'h0F;
    localparam logic [6:0] TCOU_ADDR_CMP = 7'h46;
    localparam logic [6:0] TCOU_ADDR_COUNT = 7'h47;
    localparam int TCOU_CNT_W = 12;
    localparam logic [11:0] TCOU_CNT_MAX = 12'hFFF;
    localparam logic [11:0] TCOU_CNT_ZERO = 12'h000;
    localparam logic [11:0] TCOU_CMP_RST = 12'hFFF;
    localparam logic [3:0] TCOU_GRPSEL_RST = 4'h0;
    localparam int TCOU_GRPSEL_BIT = 0;
    localparam logic [11:0] TCOU_TIMER_VECTOR = 12'h004;

    // peripheral-style register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } tcou_req_t;
endpackage

/* File: testbench/tb.sv */
// register and counter tests for the timer compare unit
// drives inputs on falling mclk edges, checks against literal expected values
`timescale 1ns/10ps
module tb;
    import tcou_pkg::*;
    logic mclk = 0, rstn = 0, clkstop_rst = 0, ce_rst = 0, count_tick = 1;
    logic count_enable = 0, count_restart = 0, repeat_mode_flag = 0;
    logic overflow_clear = 0, timer_irq_permit_flag = 0, timer_irq_clear = 0;
    logic global_irq_enabled_state = 0, external_irq_pin = 0;
    logic timer_irq_pending_flag, timer_irq_accept, count_overflow_flag;
    logic shared_group_irq;
    logic [15:0] rdata;
    logic [11:0] timer_irq_vector, count_value;
    tcou_req_t req = '0;
    int err_total = 0, tests_run = 0, gseen = 0, gbase = 0;
    logic slow = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (shared_group_irq === 1'b1) gseen++;
    always @(negedge mclk) count_tick <= slow ? !count_tick : 1'b1;
    tcou_timer_compare i_tcou_timer_compare (.*);
    task chk(input logic [15:0] g, e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge mclk) req <= '0;
        @(negedge mclk);
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e);
        req <= '{1'b0, 1'b1, a, 16'h0};
        @(negedge mclk) req <= '0;
        @(negedge mclk) chk(rdata, e);
    endtask
    task tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2000000 err_total++;
        close_out();
    end
    initial begin
        tick(3);
        rstn = 1;
        rd(TCOU_ADDR_GRPSEL, 16'h0000);
        rd(TCOU_ADDR_CMP, 16'h0FFF);
        wr(TCOU_ADDR_CMP, 16'hF003);
        rd(TCOU_ADDR_CMP, 16'h0003);
        rd(7'h10, 16'h0000);
        $display("register test done");
        repeat_mode_flag = 1;
        slow = 1;
        count_enable = 1;
        count_restart = 1;
        tick(1);
        count_restart = 0;
        repeat (20) if (timer_irq_pending_flag !== 1'b1) tick(1);
        chk(16'(timer_irq_pending_flag), 16'h1);
        repeat (12) begin
            tick(1);
            chk(16'(count_value <= 12'h3), 16'h1);
        end
        chk(16'(timer_irq_pending_flag), 16'h1);
        timer_irq_permit_flag = 1;
        global_irq_enabled_state = 1;
        repeat (5) if (timer_irq_accept !== 1'b1) tick(1);
        chk(16'(timer_irq_accept), 16'h1);
        chk(16'(timer_irq_vector), 16'h0004);
        timer_irq_permit_flag = 0;
        count_enable = 0;
        slow = 0;
        tick(3);
        timer_irq_clear = 1;
        tick(1);
        timer_irq_clear = 0;
        tick(1);
        chk(16'(timer_irq_pending_flag), 16'h0);
        $display("modulo test done");
        wr(TCOU_ADDR_GRPSEL, 16'h000F);
        rd(TCOU_ADDR_GRPSEL, 16'h0001);
        repeat_mode_flag = 0;
        count_restart = 1;
        tick(1);
        count_restart = 0;
        count_enable = 1;
        gbase = gseen;
        tick(4200);
        chk(16'(count_overflow_flag), 16'h1);
        chk(16'(count_value), 16'h0FFF);
        chk(16'(gseen - gbase), 16'h1);
        rd(TCOU_ADDR_COUNT, 16'h0FFF);
        ce_rst = 1;
        tick(1);
        ce_rst = 0;
        chk(16'(count_overflow_flag), 16'h1);
        rd(TCOU_ADDR_GRPSEL, 16'h0000);
        count_enable = 0;
        overflow_clear = 1;
        tick(1);
        overflow_clear = 0;
        tick(1);
        chk(16'(count_overflow_flag), 16'h0);
        wr(TCOU_ADDR_GRPSEL, 16'h0000);
        gbase = gseen;
        external_irq_pin = 1;
        tick(3);
        external_irq_pin = 0;
        tick(3);
        chk(16'(gseen - gbase), 16'h2);
        $display("overflow and group test done");
        close_out();
    end
endmodule // tb

/* File: testbench/tcou_chk_asserts.sv */
// checker for the timer compare unit, sees only its ports
// assumes one mclk domain and synchronous active-low rstn
`timescale 1ns/10ps
module tcou_chk import tcou_pkg::*; (
    // clock, reset and controls
    input wire logic mclk, rstn, count_tick, count_enable, count_restart,
    input wire logic repeat_mode_flag, overflow_clear, timer_irq_clear,
    input wire logic timer_irq_permit_flag, global_irq_enabled_state,
    input wire logic ce_rst, clkstop_rst, external_irq_pin,
    // status
    input wire logic timer_irq_pending_flag, timer_irq_accept,
    input wire logic count_overflow_flag, shared_group_irq,
    input wire logic [15:0] rdata,
    input wire logic [11:0] count_value
);
    wire rc = ce_rst | clkstop_rst | timer_irq_clear;
    wire arm = timer_irq_pending_flag & timer_irq_permit_flag
        & global_irq_enabled_state;
    wire go = count_enable & count_tick & !count_restart
        & !count_overflow_flag & !rc;
    wire at_max = count_value == TCOU_CNT_MAX;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_ACC: assert property (arm && !rc && !timer_irq_accept
        |=> timer_irq_accept) else $error("request not accepted");
    AST_ACC_SRC: assert property (timer_irq_accept |-> $past(arm))
        else $error("accept without cause");
    AST_PEND: assert property ($fell(timer_irq_pending_flag)
        |-> timer_irq_accept || $past(rc)) else $error("pending lost");
    AST_OVF: assert property (go && !repeat_mode_flag && at_max
        |=> count_overflow_flag && at_max) else $error("overflow missed");
    AST_STOP: assert property (count_overflow_flag && !count_restart
        && !overflow_clear |=> $stable(count_value)) else $error("ran on");
    AST_INC: assert property (go && !repeat_mode_flag && !at_max
        |=> count_value == $past(count_value) + 12'h1) else $error("step");
    AST_RDHI: assert property (rdata[15:12] == 4'h0)
        else $error("upper read bits set");
    AST_GRP: assert property (shared_group_irq
        |-> $past(external_irq_pin) != $past(external_irq_pin, 2)
        || $past(count_overflow_flag) || count_overflow_flag)
        else $error("group request without source");
endmodule // tcou_chk
bind tcou_timer_compare tcou_chk i_tcou_chk (.*);
